// ---- verilog/hcc_halt_cycle_control.sv ----
/*
  Halt and cycle control top: quarter sequencing, halt sampling, bus forcing.
  Assumes the core supplies raw strobe, bank and bus values; outputs are registered.
*/
`timescale 1ns/1ps
module hcc_halt_cycle_control (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     osc_input_a,
  input  wire logic                     osc_input_b,
  input  wire logic                     halt_n,
  input  wire logic                     core_select_cmd,
  input  wire logic                     core_write_cmd,
  input  wire logic                     core_left_bank_n,
  input  wire logic                     core_right_bank_n,
  input  wire logic [hcc_pkg::IO_W-1:0] core_io_out,
  input  wire logic                     core_io_drive,
  input  wire logic [hcc_pkg::IO_W-1:0] io_data_bus_i,
  output logic                          master_clk,
  output logic                          quarter_phase_one,
  output logic                          quarter_phase_two,
  output logic                          quarter_phase_three,
  output logic                          quarter_phase_four,
  output logic                          halted,
  output logic                          cycle_abort,
  output logic                          exec_enable,
  output logic                          select_command_strobe,
  output logic                          write_command_strobe,
  output logic                          left_bank_select_n,
  output logic                          right_bank_select_n,
  output logic [hcc_pkg::IO_W-1:0]      io_data_bus_o,
  output logic                          io_data_bus_oe,
  output logic [hcc_pkg::IO_W-1:0]      io_data_in
);
  // ----------------------------------------
  // Timing chain
  // ----------------------------------------
  logic                  half_tick;
  logic                  quarter_end;
  hcc_pkg::hcc_quarter_t quarter_r;
  logic                  osc_b_unused;

  // Second crystal pin is only the complement of the first
  assign osc_b_unused = osc_input_b;

  hcc_osc_div u_osc (
    .clk         (clk),
    .rst_n       (rst_n),
    .osc_input_a (osc_input_a),
    .half_tick   (half_tick)
  );

  hcc_quarter_gen u_qgen (
    .clk         (clk),
    .rst_n       (rst_n),
    .half_tick   (half_tick),
    .quarter_r   (quarter_r),
    .quarter_end (quarter_end)
  );

  // ----------------------------------------
  // Phase outputs and master clock
  // ----------------------------------------
  // Master clock is high in the fourth quarter; halt does not touch it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      quarter_phase_one   <= 1'b0;
      quarter_phase_two   <= 1'b0;
      quarter_phase_three <= 1'b0;
      quarter_phase_four  <= 1'b0;
      master_clk          <= 1'b0;
    end else begin
      quarter_phase_one   <= (quarter_r == hcc_pkg::HCC_Q1);
      quarter_phase_two   <= (quarter_r == hcc_pkg::HCC_Q2);
      quarter_phase_three <= (quarter_r == hcc_pkg::HCC_Q3);
      quarter_phase_four  <= (quarter_r == hcc_pkg::HCC_Q4);
      master_clk          <= (quarter_r == hcc_pkg::HCC_Q4);
    end
  end

  // ----------------------------------------
  // Halt sampling
  // ----------------------------------------
  logic sample_pt;
  logic halt_r;

  assign sample_pt = quarter_end && (quarter_r == hcc_pkg::HCC_Q1);

  // Reset holds the flag clear and skips sampling; core state is never reset here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      halt_r      <= 1'b0;
      cycle_abort <= 1'b0;
    end else begin
      cycle_abort <= sample_pt && !halt_n && !halt_r;
      if (sample_pt)
        halt_r <= !halt_n;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      halted      <= 1'b0;
      exec_enable <= 1'b0;
    end else begin
      halted      <= sample_pt ? !halt_n : halt_r;
      exec_enable <= !(sample_pt ? !halt_n : halt_r);
    end
  end

  // ----------------------------------------
  // Bus forcing
  // ----------------------------------------
  logic force_idle;

  // Forcing starts on the very sample edge so nothing of the aborted cycle leaks out
  assign force_idle = sample_pt ? !halt_n : halt_r;

  always_ff @(posedge clk) begin
    if (!rst_n || force_idle) begin
      select_command_strobe <= 1'b0;
      write_command_strobe  <= 1'b0;
    end else begin
      select_command_strobe <= core_select_cmd;
      write_command_strobe  <= core_write_cmd;
    end
  end

  // Bank decode relies on a stable instruction from program storage
  always_ff @(posedge clk) begin
    if (!rst_n || force_idle) begin
      left_bank_select_n  <= 1'b1;
      right_bank_select_n <= 1'b1;
    end else begin
      left_bank_select_n  <= core_left_bank_n;
      right_bank_select_n <= core_right_bank_n;
    end
  end

  // Drive only from the third quarter, after the input device has let go
  always_ff @(posedge clk) begin
    if (!rst_n || force_idle) begin
      io_data_bus_oe <= 1'b0;
      io_data_bus_o  <= hcc_pkg::IO_RST;
    end else begin
      io_data_bus_oe <= core_io_drive &&
                        (quarter_r == hcc_pkg::HCC_Q3 || quarter_r == hcc_pkg::HCC_Q4);
      io_data_bus_o  <= core_io_out;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      io_data_in <= hcc_pkg::IO_RST;
    else if (quarter_end && quarter_r == hcc_pkg::HCC_Q2)
      io_data_in <= io_data_bus_i;
  end
endmodule : hcc_halt_cycle_control

// ---- verilog/hcc_pkg.sv ----
/*
  Constants and types for the halt and cycle control block.
  Assumes one 250 MHz clock, synchronous active-low reset, no software registers.
*/
package hcc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 4000;
  localparam int unsigned MIN_CYCLE_NS    = 200;
  localparam int unsigned MIN_CYCLE_CLKS  = (MIN_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned MIN_QUARTER_CLKS = (MIN_CYCLE_CLKS + 3) / 4;
  localparam int unsigned OSC_PER_CYCLE   = 2;
  localparam int unsigned QCNT_W          = 8;
  localparam logic [QCNT_W-1:0] QUARTER_CLKS_DEF = QCNT_W'(MIN_QUARTER_CLKS);
  localparam logic [QCNT_W-1:0] QCNT_RST  = 8'h00;
  localparam int unsigned IO_W            = 8;
  localparam logic [IO_W-1:0] IO_RST      = 8'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    HCC_Q1,
    HCC_Q2,
    HCC_Q3,
    HCC_Q4
  } hcc_quarter_t;
endpackage : hcc_pkg

// ---- verilog/hcc_osc_div.sv ----
/*
  Oscillator edge detector: turns osc_input_a into a one-clock tick per oscillator half period.
  Assumes osc_input_a is synchronous to clk.
*/
`timescale 1ns/1ps
module hcc_osc_div (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic osc_input_a,
  output logic      half_tick
);
  logic osc_prev_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Follow the pin level in reset so a high idle pin gives no false tick at release
      osc_prev_r <= osc_input_a;
      half_tick  <= 1'b0;
    end else begin
      osc_prev_r <= osc_input_a;
      half_tick  <= osc_input_a ^ osc_prev_r;
    end
  end
endmodule : hcc_osc_div

// ---- verilog/hcc_quarter_gen.sv ----
/*
  Quarter phase generator: each oscillator half period is one quarter, so a cycle is two
  oscillator periods. A floor count keeps each quarter at least the minimum length.
  Assumes half_tick from the oscillator detector.
*/
`timescale 1ns/1ps
module hcc_quarter_gen (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 half_tick,
  output hcc_pkg::hcc_quarter_t     quarter_r,
  output logic                      quarter_end
);
  logic [hcc_pkg::QCNT_W-1:0] cnt_r;
  logic                       pend_r;
  logic                       adv;

  // A tick before the floor is held in pend_r; any other tick up to the advancing clock is dropped
  assign adv = (half_tick || pend_r) && (cnt_r >= hcc_pkg::QUARTER_CLKS_DEF - 8'h01);
  assign quarter_end = adv;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r     <= hcc_pkg::QCNT_RST;
      pend_r    <= 1'b0;
      quarter_r <= hcc_pkg::HCC_Q1;
    end else if (adv) begin
      cnt_r     <= hcc_pkg::QCNT_RST;
      pend_r    <= 1'b0;
      quarter_r <= hcc_pkg::hcc_quarter_t'(quarter_r + 2'h1);
    end else begin
      if (cnt_r != 8'hff)
        cnt_r <= cnt_r + 8'h01;
      if (half_tick)
        pend_r <= 1'b1;
    end
  end
endmodule : hcc_quarter_gen

// ---- verif/hcc_port_model.sv ----
/* I/O port model on the far side of the data bus.
   Assumes bank selects and bus enable come from the block. */
`timescale 1ns/1ps
module hcc_port_model (
  input  wire logic       clk,
  input  wire logic       left_n,
  input  wire logic       right_n,
  input  wire logic       oe,
  input  wire logic [7:0] bus_o,
  output logic      [7:0] bus_i
);
  logic [7:0] dat_r = 8'h00;
  // Unselected bus wanders so stale data never looks valid
  always_ff @(posedge clk) dat_r <= dat_r + 8'h35;
  always_comb bus_i = oe ? bus_o : (!left_n || !right_n) ? 8'ha5 : dat_r;
endmodule : hcc_port_model

// ---- verif/hcc_checker_assertions.sv ----
/* Port assertions for halt and cycle control.
   Assumes binding to the top module, one clock. */
`timescale 1ns/1ps
module hcc_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic halted,
  input wire logic cycle_abort,
  input wire logic master_clk,
  input wire logic quarter_phase_one,
  input wire logic quarter_phase_two,
  input wire logic quarter_phase_four,
  input wire logic select_command_strobe,
  input wire logic write_command_strobe,
  input wire logic left_bank_select_n,
  input wire logic right_bank_select_n,
  input wire logic io_data_bus_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----
  // Halt and quarter rules
  // ----
  property p_strb; halted |-> !select_command_strobe && !write_command_strobe; endproperty
  a_strb: assert property (p_strb) else $error("strobe in halt");
  property p_bank; halted |-> left_bank_select_n && right_bank_select_n; endproperty
  a_bank: assert property (p_bank) else $error("bank in halt");
  property p_bus; halted |-> !io_data_bus_oe; endproperty
  a_bus: assert property (p_bus) else $error("bus driven in halt");
  property p_abort; cycle_abort == $rose(halted); endproperty
  a_abort: assert property (p_abort) else $error("abort pulse wrong");
  property p_smp; $changed(halted) |-> quarter_phase_one ##1 quarter_phase_two; endproperty
  a_smp: assert property (p_smp) else $error("halt moved off sample");
  property p_mclk; halted |-> ##[1:70] $changed(master_clk); endproperty
  a_mclk: assert property (p_mclk) else $error("master clock stopped");
  property p_minq; $rose(quarter_phase_two) |-> quarter_phase_two[*8]; endproperty
  a_minq: assert property (p_minq) else $error("quarter too short");
  property p_ord; $fell(quarter_phase_four) |-> quarter_phase_one; endproperty
  a_ord: assert property (p_ord) else $error("quarter order");
  // Reset must win even with halt low, so no disable here
  property p_rst; disable iff (1'b0) !rst_n |=> !halted; endproperty
  a_rst: assert property (p_rst) else $error("halt in reset");
  cover property ($rose(halted));
  cover property ($fell(halted));
  cover property (halted && master_clk);
endmodule : hcc_checker
bind hcc_halt_cycle_control hcc_checker u_chk (.*);

// ---- verif/halt_cycle_control_test.sv ----
/* Random bench for halt and cycle control.
   Assumes a 4 ns clock; oscillator toggles every 16 clocks. */
`timescale 1ns/1ps
module halt_cycle_control_test;
  logic       clk = 0, rst_n = 0, osc_input_a = 0, osc_input_b = 1, halt_n = 0;
  logic       core_select_cmd = 0, core_write_cmd = 0, core_left_bank_n = 1, core_right_bank_n = 1;
  logic       core_io_drive = 0, hexp = 0, q1_p, q2_p, rs = 0, h_p = 0;
  logic [7:0] core_io_out = 0, io_data_bus_i, io_data_bus_o, io_data_in;
  logic       master_clk, quarter_phase_one, quarter_phase_two, quarter_phase_three, quarter_phase_four;
  logic       halted, cycle_abort, exec_enable, select_command_strobe, write_command_strobe;
  logic       left_bank_select_n, right_bank_select_n, io_data_bus_oe;
  logic [1:0] hq = 0;
  logic [3:0] pv = 0;
  int         err_count = 0, n_checks = 0, seed = 32'h4521, i, oc = 0, cyc = 200, nq1 = 0;
  hcc_halt_cycle_control dut (.*);
  hcc_port_model u_port (.clk(clk), .left_n(left_bank_select_n), .right_n(right_bank_select_n),
    .oe(io_data_bus_oe), .bus_o(io_data_bus_o), .bus_i(io_data_bus_i));
  initial forever #2 clk = ~clk;
  // ----
  // Expectation and checks
  // ----
  function automatic logic [3:0] exp_ctl(input logic h, input logic [3:0] core);
    return h ? 4'h3 : core;
  endfunction : exp_ctl
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    oc <= oc + 1;
    if (oc % 16 == 15) begin
      osc_input_a <= !osc_input_a;
      osc_input_b <= osc_input_a;
    end
    hq <= {hq[0], halt_n};
    pv <= {core_select_cmd, core_write_cmd, core_left_bank_n, core_right_bank_n};
    rs <= rst_n;
  end
  // Skip quarter one: halt settles there a clock before the phase flags move
  always @(negedge clk) begin
    if (!rs) begin
      hexp = 0;
      cyc = 200;
      nq1 = 0;
    end else begin
      cyc++;
      if (quarter_phase_one && !q1_p) begin
        // Quarters slip onto the oscillator after reset, so the first cycles run short
        if (nq1 >= 3) check("cycle", 8'(cyc), 8'h40);
        if (nq1 < 3) nq1++;
        cyc = 0;
      end
      if (quarter_phase_two && !q2_p) hexp = !hq[1];
      if (!quarter_phase_one) begin
        check("halted", {7'h0, halted}, {7'h0, hexp});
        check("exec", {7'h0, exec_enable}, {7'h0, !hexp});
        check("ctl", {4'h0, select_command_strobe, write_command_strobe, left_bank_select_n,
          right_bank_select_n}, {4'h0, exp_ctl(hexp, pv)});
        if (hexp) check("oe", {7'h0, io_data_bus_oe}, 8'h00);
      end
      check("abort", {7'h0, cycle_abort}, {7'h0, halted && !h_p});
      check("mclk", {7'h0, master_clk}, {7'h0, quarter_phase_four});
      if (io_data_bus_oe) check("oe_q", {7'h0, quarter_phase_three || quarter_phase_four}, 8'h01);
    end
    q1_p = quarter_phase_one;
    q2_p = quarter_phase_two;
    h_p = halted;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      {core_select_cmd, core_write_cmd, core_left_bank_n, core_right_bank_n, core_io_drive} <= 5'($random(seed));
      core_io_out <= 8'($random(seed));
      if (i < 300 || (i >= 1500 && i < 1504)) halt_n <= 0;
      else if (i >= 2000 && i < 2600) halt_n <= !quarter_phase_three;
      else if (i % 48 == 0) halt_n <= 1'($random(seed));
      rst_n <= !(i >= 1500 && i < 1504);
    end
    final_report;
  end
endmodule : halt_cycle_control_test
